// ===== serial_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-end serial peripheral
// ----------------------------------------
module serial_peer #(
    parameter int BIT = 64 // Same bit time as the port
) (
    input  wire logic hclk,
    input  wire logic txd,
    output logic      rxd
);
    // Marking level between frames
    initial rxd = 1'b1;
    // One frame: start, data LSB first, optional parity, one stop
    task send(input logic [7:0] d, input int nb, input logic pen, input logic pv);
        int i;
        @(posedge hclk);
        rxd <= 1'b0;
        repeat (BIT) @(posedge hclk);
        for (i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (BIT) @(posedge hclk);
        end
        if (pen) begin
            rxd <= pv;
            repeat (BIT) @(posedge hclk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge hclk);
    endtask
    // Sample each bit at its centre; return after the stop bit ends
    task recv(input int nb, input logic pen, output logic [7:0] d, output logic p, output logic s);
        int i;
        d = 8'h00;
        p = 1'b0;
        @(negedge txd);
        repeat (BIT / 2) @(posedge hclk);
        for (i = 0; i < nb; i++) begin
            repeat (BIT) @(posedge hclk);
            d[i] = txd;
        end
        if (pen) begin
            repeat (BIT) @(posedge hclk);
            p = txd;
        end
        repeat (BIT) @(posedge hclk);
        s = txd;
        repeat (BIT / 2) @(posedge hclk);
    endtask
endmodule // serial_peer

// ===== serial_port.v
`timescale 1ns/1ps
`include "uart_map.vh"

// How it works
// - Receiver times frame bits from start bit
// - Data length selectable 5 to 8 bits
// - Next frame follows last stop bit directly
// - Four-bit code picks baud, default 2400
// - Software may override switch-preset configuration
// - Terminal-ready output shows readiness
// - Request-to-send shows data waiting to send
// - Always-on switch forces status input high
// - Status lines checked only when enabled, default off
// - Bits 7:6 select flow control mode
// - Bits 5:3 select parity sense
// - Bit 2 stop bits, bits 1:0 length
// - Received ENQ answered with ACK
// - XOFF halts transmission except own XON/XOFF, XON resumes it
// - Send XOFF when buffer low, XON when drained
// - Parity mismatch flags character as error
// - Odd parity: bit set for even ones
// - Even parity: bit set for odd ones
// - Always-one parity sent and checked
// - Always-zero parity sent and checked
// - Modem checking gates receive and transmit
module serial_port #(
    parameter CLK_HZ   = `CLK_HZ,
    parameter RX_DEPTH = 8,
    parameter RX_AW    = 3
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Default switches
    input  wire [7:0]  sw_line,
    input  wire [3:0]  sw_rate,
    input  wire [3:0]  sw_always_on,
    // Serial line and modem lines
    output reg         txd,
    input  wire        rxd,
    output wire        terminal_ready_out,
    output wire        request_to_send_out,
    input  wire        data_set_ready_in,
    input  wire        clear_to_send_in,
    input  wire        carrier_detect_in,
    input  wire        ring_indicate_in
);

// ----------------------------------------
// Configuration registers
// ----------------------------------------
reg  [7:0] line;
reg  [3:0] rate;
reg  [7:0] modem;
reg        init_done;
reg        hold_full;
reg  [7:0] hold;
reg        par_err;
reg        frm_err;
reg        overrun;
reg [RX_AW:0] rx_cnt;

wire [3:0] dlen     = {2'b00, line[`LEN_LSB+1:`LEN_LSB]} + 4'd5;
wire [2:0] par_mode = line[`PAR_LSB+2:`PAR_LSB];
wire       par_on   = par_mode[0];
wire       two_stop = line[`STOP_BIT];
wire [1:0] flow     = line[`FLOW_LSB+1:`FLOW_LSB];

// Status inputs, forced true by the always-on switches
wire dsr_ok = sw_always_on[0] | data_set_ready_in;
wire cts_ok = sw_always_on[1] | clear_to_send_in;
wire car_ok = sw_always_on[2] | carrier_detect_in;
wire ring_ok = sw_always_on[3] | ring_indicate_in;
wire chk    = modem[`MDM_CHECK];
wire tx_ok  = ~chk | (dsr_ok & cts_ok);
wire rx_ok  = ~chk | (dsr_ok & car_ok);

// ----------------------------------------
// Baud tick at sixteen times the bit rate
// ----------------------------------------
function [15:0] div_of;
    input [3:0] c;
    integer t;
    begin
        case (c)
            4'h0: t = `DIV16(CLK_HZ, `BAUD_X10_0);
            4'h1: t = `DIV16(CLK_HZ, `BAUD_X10_1);
            4'h2: t = `DIV16(CLK_HZ, `BAUD_X10_2);
            4'h3: t = `DIV16(CLK_HZ, `BAUD_X10_3);
            4'h4: t = `DIV16(CLK_HZ, `BAUD_X10_4);
            4'h5: t = `DIV16(CLK_HZ, `BAUD_X10_5);
            4'h6: t = `DIV16(CLK_HZ, `BAUD_X10_6);
            4'h7: t = `DIV16(CLK_HZ, `BAUD_X10_7);
            4'h8: t = `DIV16(CLK_HZ, `BAUD_X10_8);
            4'h9: t = `DIV16(CLK_HZ, `BAUD_X10_9);
            4'ha: t = `DIV16(CLK_HZ, `BAUD_X10_A);
            4'hb: t = `DIV16(CLK_HZ, `BAUD_X10_B);
            4'hc: t = `DIV16(CLK_HZ, `BAUD_X10_C);
            4'hd: t = `DIV16(CLK_HZ, `BAUD_X10_D);
            4'he: t = `DIV16(CLK_HZ, `BAUD_X10_E);
            default: t = `DIV16(CLK_HZ, `BAUD_X10_F);
        endcase
        if (t < 1)
            t = 1;
        div_of = t[15:0];
    end
endfunction

reg  [15:0] bcnt;
wire [15:0] bdiv = div_of(rate);
wire        tick = (bcnt >= bdiv - 16'h0001);

// Counter restarts at once when a rate change drops the divisor below it, because it compares with >=
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
        bcnt <= 16'h0000;
    else if (tick)
        bcnt <= 16'h0000;
    else
        bcnt <= bcnt + 16'h0001;
end

// Parity bit for a character under the given sense
function par_of;
    input [2:0] m;
    input [7:0] d;
    begin
        case (m)
            `PAR_ODD:  par_of = ~^d;
            `PAR_EVEN: par_of = ^d;
            `PAR_ONE:  par_of = 1'b1;
            default:   par_of = 1'b0;
        endcase
    end
endfunction

reg  [7:0] dmask;
always @* begin
    case (line[1:0])
        2'b00:   dmask = 8'h1f;
        2'b01:   dmask = 8'h3f;
        2'b10:   dmask = 8'h7f;
        default: dmask = 8'hff;
    endcase
end

// ----------------------------------------
// Transmit source selection
// ----------------------------------------
reg        ack_pend;
reg        flow_pend;
reg  [7:0] flow_char;
reg        tx_stop;
reg  [7:0] tx_left;
reg  [3:0] tx_ph;
reg [11:0] tx_sh;

// Own flow characters pass an XOFF hold, else both ends could wait forever
wire tx_done = (tx_left == 8'h01) & tick;
wire tx_free = (tx_left == 8'h00) | tx_done;
wire sel_ack = tx_ok & ~tx_stop & ack_pend;
wire sel_flw = tx_ok & ~sel_ack & flow_pend;
wire sel_hld = tx_ok & ~tx_stop & ~ack_pend & ~flow_pend & hold_full;
// Loads only on a tick, so the start bit lasts sixteen ticks like every bit except the half stop bit of a 5-bit two-stop frame
wire tx_load = tx_free & tick & (sel_ack | sel_flw | sel_hld);
wire [7:0] tx_char = sel_ack ? `CH_ACK : (sel_flw ? flow_char : hold);

// Frame bits, start bit first, padded with stop level
reg [11:0] frame;
reg  [7:0] flen;
integer    i;
always @* begin
    frame = 12'hfff;
    frame[0] = 1'b0;
    for (i = 0; i < 8; i = i + 1)
        if (i < dlen)
            frame[i + 1] = tx_char[i];
    if (par_on)
        frame[dlen + 1] = par_of(par_mode, tx_char & dmask);
    flen = {dlen + {3'b000, par_on} + 4'd2, 4'h0};
    if (two_stop)
        flen = flen + ((dlen == 4'd5) ? 8'd8 : 8'd16);
end

// ----------------------------------------
// Transmitter
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        tx_sh   <= 12'hfff;
        tx_left <= 8'h00;
        tx_ph   <= 4'h0;
        txd     <= 1'b1;
    end else begin
        if (tx_load) begin
            tx_sh   <= frame;
            tx_left <= flen;
            tx_ph   <= 4'h0;
        end else if (tick && tx_left != 8'h00) begin
            tx_left <= tx_left - 8'h01;
            tx_ph   <= tx_ph + 4'h1;
            if (tx_ph == 4'hf)
                tx_sh <= {1'b1, tx_sh[11:1]};
        end
        txd <= tx_sh[0];
    end
end

// ----------------------------------------
// Receiver
// ----------------------------------------
reg        rx_busy;
reg        rx_start;
reg  [3:0] rx_ph;
reg  [3:0] rx_n;
reg  [7:0] rx_sh;
reg        rx_par;
reg  [7:0] rx_mem [0:RX_DEPTH-1];
reg [RX_AW-1:0] rx_wp;
reg [RX_AW-1:0] rx_rp;
reg        rx_pop;
reg        rx_push;
reg  [7:0] rx_word;
reg        rx_bad;
reg        rx_ovr;

wire [3:0] rx_last = dlen + {3'b000, par_on};
wire       rx_smp  = tick & (rx_start ? (rx_ph == 4'h7) : (rx_ph == 4'hf));

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rx_busy  <= 1'b0;
        rx_start <= 1'b0;
        rx_ph    <= 4'h0;
        rx_n     <= 4'h0;
        rx_sh    <= 8'h00;
        rx_par   <= 1'b0;
        rx_push  <= 1'b0;
        rx_word  <= 8'h00;
        rx_bad   <= 1'b0;
        rx_ovr   <= 1'b0;
    end else begin
        rx_push <= 1'b0;
        rx_bad  <= 1'b0;
        rx_ovr  <= 1'b0;
        if (!rx_busy) begin
            if (tick && !rxd) begin
                rx_busy  <= 1'b1;
                rx_start <= 1'b1;
                rx_ph    <= 4'h0;
                rx_n     <= 4'h0;
                rx_sh    <= 8'h00;
            end
        end else if (tick) begin
            rx_ph <= rx_smp ? 4'h0 : rx_ph + 4'h1;
            if (rx_smp && rx_start) begin
                rx_start <= 1'b0;
                if (rxd)
                    rx_busy <= 1'b0;                                          // Glitch, not a start bit
            end else if (rx_smp) begin
                rx_n <= rx_n + 4'h1;
                if (rx_n < dlen)
                    rx_sh[rx_n[2:0]] <= rxd;
                else if (rx_n < rx_last)
                    rx_par <= rxd;
                else begin
                    rx_busy <= 1'b0;
                    frm_err_set(rxd);
                end
            end
        end
    end
end

// Stop-bit sample: decide what happens to the finished character
task frm_err_set;
    input stop_lvl;
    begin
        if (rx_ok) begin
            rx_word <= rx_sh;
            rx_bad  <= ~stop_lvl;
            if (!(flow == `FLOW_ENQ && rx_sh == `CH_ENQ) &&
                !(flow == `FLOW_XON && (rx_sh == `CH_XON || rx_sh == `CH_XOFF))) begin
                rx_push <= (rx_cnt != RX_DEPTH);
                rx_ovr  <= (rx_cnt == RX_DEPTH);
            end
        end
    end
endtask

// Parity check on the captured character
wire rx_perr = par_on & (rx_par != par_of(par_mode, rx_word & dmask));
reg  rx_perr_ev;
reg  rx_done;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rx_done    <= 1'b0;
        rx_perr_ev <= 1'b0;
    end else begin
        rx_done    <= rx_smp & ~rx_start & rx_busy & (rx_n >= rx_last) & rx_ok;
        rx_perr_ev <= 1'b0;
        if (rx_done)
            rx_perr_ev <= rx_perr;
    end
end

// Receive buffer
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rx_wp  <= {RX_AW{1'b0}};
        rx_rp  <= {RX_AW{1'b0}};
        rx_cnt <= {(RX_AW+1){1'b0}};
    end else begin
        if (rx_push)
            rx_wp <= rx_wp + 1'b1;
        if (rx_pop)
            rx_rp <= rx_rp + 1'b1;
        rx_cnt <= rx_cnt + {{RX_AW{1'b0}}, rx_push} - {{RX_AW{1'b0}}, rx_pop};
    end
end

always @(posedge hclk) begin
    if (rx_push)
        rx_mem[rx_wp] <= rx_word;
end

// ----------------------------------------
// Software handshake
// ----------------------------------------
reg xoff_sent;
wire rx_low = (rx_cnt >= RX_DEPTH - 2);
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ack_pend  <= 1'b0;
        flow_pend <= 1'b0;
        flow_char <= `CH_XON;
        xoff_sent <= 1'b0;
        tx_stop   <= 1'b0;
    end else begin
        // Answer each ENQ received without framing error; a new one while pending merges, and a new ENQ beats the clear
        if (tx_load && sel_ack)
            ack_pend <= 1'b0;
        if (rx_bad == 1'b0 && rx_done && flow == `FLOW_ENQ && rx_word == `CH_ENQ)
            ack_pend <= 1'b1;
        if (flow != `FLOW_XON)
            tx_stop <= 1'b0;
        else if (rx_done && rx_word == `CH_XOFF)
            tx_stop <= 1'b1;
        else if (rx_done && rx_word == `CH_XON)
            tx_stop <= 1'b0;
        if (tx_load && sel_flw)
            flow_pend <= 1'b0;
        else if (!flow_pend && flow == `FLOW_XON) begin
            if (!xoff_sent && rx_low) begin
                flow_pend <= 1'b1;
                flow_char <= `CH_XOFF;
                xoff_sent <= 1'b1;
            end else if (xoff_sent && rx_cnt == 0) begin
                flow_pend <= 1'b1;
                flow_char <= `CH_XON;
                xoff_sent <= 1'b0;
            end
        end
    end
end

// ----------------------------------------
// AHB-Lite slave, zero wait, always OKAY
// ----------------------------------------
reg        wr_ph;
reg [11:0] wr_adr;
wire       acc = hsel & hready & htrans[1];

assign hreadyout           = 1'b1;
assign hresp               = 1'b0;
assign terminal_ready_out  = modem[`MDM_DTR];
assign request_to_send_out = hold_full | ack_pend | flow_pend | (tx_left != 8'h00);

wire [31:0] status = {20'h00000, {(4-RX_AW){1'b0}}, rx_cnt[RX_AW-1:0] | {RX_AW{rx_cnt[RX_AW]}},
                      xoff_sent, tx_stop, overrun, frm_err, par_err,
                      (tx_left == 8'h00), ~hold_full, (rx_cnt != 0)};

// Read data is registered in the address phase, so a read pops the buffer once
always @* begin
    rx_pop = acc & ~hwrite & (haddr == `OFS_DATA) & (rx_cnt != 0);
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata    <= 32'h00000000;
        wr_ph     <= 1'b0;
        wr_adr    <= 12'h000;
        line      <= 8'h00;
        rate      <= 4'h0;
        modem     <= `MDM_RST;
        init_done <= 1'b0;
        hold_full <= 1'b0;
        hold      <= 8'h00;
        par_err   <= 1'b0;
        frm_err   <= 1'b0;
        overrun   <= 1'b0;
    end else begin
        wr_ph  <= acc & hwrite;
        wr_adr <= haddr;
        if (!init_done) begin
            init_done <= 1'b1;
            line      <= sw_line;
            rate      <= sw_rate;
        end
        if (acc && !hwrite) begin
            case (haddr)
                `OFS_LINE:   hrdata <= {24'h000000, line};
                `OFS_RATE:   hrdata <= {28'h0000000, rate};
                `OFS_MODEM:  hrdata <= {24'h000000, ring_ok, car_ok, cts_ok, dsr_ok, modem[3:0]};
                `OFS_DATA:   hrdata <= {24'h000000, (rx_cnt != 0) ? rx_mem[rx_rp] : 8'h00};
                `OFS_STATUS: hrdata <= status;
                default:     hrdata <= 32'h00000000;
            endcase
        end
        if (tx_load && sel_hld)
            hold_full <= 1'b0;
        if (wr_ph) begin
            case (wr_adr)
                `OFS_LINE:  line  <= hwdata[7:0];
                `OFS_RATE:  rate  <= hwdata[3:0];
                `OFS_MODEM: modem <= {6'h00, hwdata[1:0]};
                `OFS_DATA: begin
                    if (!hold_full) begin
                        hold      <= hwdata[7:0] & dmask;
                        hold_full <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Error flags: write one to clear, a new event wins
        par_err <= (par_err & ~(wr_ph & (wr_adr == `OFS_STATUS) & hwdata[3])) | rx_perr_ev;
        frm_err <= (frm_err & ~(wr_ph & (wr_adr == `OFS_STATUS) & hwdata[4])) | rx_bad;
        overrun <= (overrun & ~(wr_ph & (wr_adr == `OFS_STATUS) & hwdata[5])) | rx_ovr;
    end
end

endmodule // serial_port

// ===== serial_port_chk.sv
`timescale 1ns/1ps
`include "uart_map.vh"
// ----------------------------------------
// Port checks for the serial port
// ----------------------------------------
module serial_port_chk #(
    parameter CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Line side
    input wire logic        txd,
    input wire logic        terminal_ready_out,
    input wire logic        request_to_send_out
);
    // Bit time holds only while the preset rate is kept
    localparam int BIT = `OVS * `DIV16(CLK_HZ, `BAUD_X10_A);
    logic [15:0] lo_cnt;
    wire         rd_req = hsel && hready && htrans[1] && !hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Length of the current low run on the line
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            lo_cnt <= 16'h0000;
        else if (!txd)
            lo_cnt <= lo_cnt + 16'h0001;
        else
            lo_cnt <= 16'h0000;
    end
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("bus wait state seen");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_idle; $rose(hresetn) |-> txd && !request_to_send_out; endproperty
    a_idle: assert property (p_idle) else $error("line not idle after reset");
    property p_dtr; $rose(hresetn) |-> terminal_ready_out; endproperty
    a_dtr: assert property (p_dtr) else $error("ready low after reset");
    // Low runs are whole bits, never longer than start, data and parity
    property p_bit; $rose(txd) |-> (lo_cnt % BIT == 0) && (lo_cnt <= 10 * BIT); endproperty
    a_bit: assert property (p_bit) else $error("odd low run length");
    property p_rts; $fell(txd) |-> request_to_send_out; endproperty
    a_rts: assert property (p_rts) else $error("frame without send request");
    property p_unmap; rd_req && haddr > 12'h010 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !rd_req |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_upper; rd_req |=> hrdata[31:12] == 20'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule // serial_port_chk

bind serial_port serial_port_chk #(.CLK_HZ(CLK_HZ)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .txd(txd), .terminal_ready_out(terminal_ready_out),
    .request_to_send_out(request_to_send_out)
);

// ===== tb_async_serial_port_with_handshake.sv
`timescale 1ns/1ps
`include "uart_map.vh"
module tb_async_serial_port_with_handshake;
    // Small clock figure keeps bit times short
    localparam int         CLK  = 160000;
    localparam int         BIT  = `OVS * `DIV16(CLK, `BAUD_X10_A);
    localparam logic [3:0] PEXP = 4'b0110;
    logic        hclk, hresetn, hsel, hwrite, hreadyout;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rv;
    logic [7:0]  rc;
    logic [3:0]  always_on;
    logic        txd, rxd, dtr, rts, dsr, cts, carrier, ring, rp, rs;
    int          error_cnt, n_tests;

    serial_port #(.CLK_HZ(CLK)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .sw_line(8'h03),
        .sw_rate(4'ha), .sw_always_on(always_on), .txd(txd), .rxd(rxd),
        .terminal_ready_out(dtr), .request_to_send_out(rts), .data_set_ready_in(dsr),
        .clear_to_send_in(cts), .carrier_detect_in(carrier), .ring_indicate_in(ring)
    );
    serial_peer #(.BIT(BIT)) peer_u (.hclk(hclk), .txd(txd), .rxd(rxd));

    // Clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Single transfer; address held until ready, data until ready again
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a);
        ahb(1'b0, a, 32'h0);
    endtask
    task results;
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task reset_regs;
        chk("idle line", txd, 1);
        chk("ready", dtr, 1);
        rd(`OFS_LINE);
        chk("line", rv, 32'h03);
        rd(`OFS_RATE);
        chk("rate", rv, 32'ha);
        rd(`OFS_MODEM);
        chk("modem", rv[1:0], 2'b10);
        wr(12'h040, 32'hff);
        rd(12'h040);
        chk("unmapped", rv, 32'h0);
        wr(`OFS_LINE, 32'hc3);
        rd(`OFS_LINE);
        chk("line written", rv, 32'hc3);
    endtask
    task enq_ack;
        wr(`OFS_LINE, 32'h03);
        fork
            peer_u.send(`CH_ENQ, 8, 1'b0, 1'b0);
            peer_u.recv(8, 1'b0, rc, rp, rs);
        join
        chk("ack", rc, `CH_ACK);
        rd(`OFS_STATUS);
        chk("enq unbuffered", rv[11:8], 4'h0);
    endtask
    // Every parity sense, each at its own length from 5 to 8 bits, both directions
    task parity_modes;
        int i;
        for (i = 0; i < 4; i++) begin
            wr(`OFS_LINE, {24'h0, 2'b11, i[1:0], 2'b10, i[1:0]});
            fork
                wr(`OFS_DATA, 32'h16);
                peer_u.recv(5 + i, 1'b1, rc, rp, rs);
            join
            chk("tx data", rc, 8'h16);
            chk("tx parity", rp, PEXP[i]);
            chk("tx stop", rs, 1);
            peer_u.send(8'h16, 5 + i, 1'b1, ~PEXP[i]);
            rd(`OFS_STATUS);
            chk("parity error", rv[3], 1);
            wr(`OFS_STATUS, 32'h08);
            peer_u.send(8'h16, 5 + i, 1'b1, PEXP[i]);
            rd(`OFS_STATUS);
            chk("parity clean", rv[3], 0);
            rd(`OFS_DATA);
            chk("rx bad char", rv, 32'h16);
            rd(`OFS_DATA);
            chk("rx good char", rv, 32'h16);
        end
    endtask
    task modem_gate;
        wr(`OFS_LINE, 32'hc3);
        wr(`OFS_MODEM, 32'h01);
        // The register takes the write on the edge the task returns at
        @(posedge hclk);
        chk("ready off", dtr, 0);
        cts <= 1'b0;
        carrier <= 1'b0;
        wr(`OFS_DATA, 32'h55);
        repeat (4 * BIT) @(posedge hclk);
        chk("tx held", txd, 1);
        chk("send request", rts, 1);
        peer_u.send(8'h33, 8, 1'b0, 1'b0);
        rd(`OFS_STATUS);
        chk("rx gated", rv[11:8], 4'h0);
        // Forcing the missing lines high releases the held character
        fork
            begin
                @(posedge hclk);
                always_on <= 4'h6;
            end
            peer_u.recv(8, 1'b0, rc, rp, rs);
        join
        chk("forced lines", rc, 8'h55);
        rd(`OFS_MODEM);
        chk("effective lines", rv[6:5], 2'b11);
        wr(`OFS_MODEM, 32'h02);
        always_on <= 4'h0;
        cts <= 1'b1;
        carrier <= 1'b1;
    endtask
    task xon_xoff;
        wr(`OFS_LINE, 32'h43);
        peer_u.send(`CH_XOFF, 8, 1'b0, 1'b0);
        wr(`OFS_DATA, 32'h41);
        repeat (4 * BIT) @(posedge hclk);
        chk("xoff hold", txd, 1);
        rd(`OFS_STATUS);
        chk("stopped flag", rv[6], 1);
        fork
            peer_u.send(`CH_XON, 8, 1'b0, 1'b0);
            peer_u.recv(8, 1'b0, rc, rp, rs);
        join
        chk("resumed", rc, 8'h41);
        // Six unread characters reach the low-space mark of an 8-deep buffer
        fork
            for (int i = 0; i < 6; i++) peer_u.send(8'h20 + i[7:0], 8, 1'b0, 1'b0);
            peer_u.recv(8, 1'b0, rc, rp, rs);
        join
        chk("own xoff", rc, `CH_XOFF);
        fork
            repeat (6) rd(`OFS_DATA);
            peer_u.recv(8, 1'b0, rc, rp, rs);
        join
        chk("own xon", rc, `CH_XON);
    endtask
    // Watchdog
    initial begin
        repeat (80000) @(posedge hclk);
        error_cnt++;
        results;
    end
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwdata = 32'h0;
        always_on = 4'h0;
        dsr = 1'b1;
        cts = 1'b1;
        carrier = 1'b1;
        ring = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        reset_regs;
        enq_ack;
        parity_modes;
        modem_gate;
        xon_xoff;
        results;
    end
endmodule // tb_async_serial_port_with_handshake

// ===== uart_map.vh
`ifndef UART_MAP_VH
`define UART_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_LINE   12'h000
`define OFS_RATE   12'h004
`define OFS_MODEM  12'h008
`define OFS_DATA   12'h00c
`define OFS_STATUS 12'h010
// ----------------------------------------
// Line control fields and codes
// ----------------------------------------
`define LEN_LSB    0
`define STOP_BIT   2
`define PAR_LSB    3
`define FLOW_LSB   6
`define FLOW_ENQ   2'b00
`define FLOW_XON   2'b01
`define PAR_ODD    3'b001
`define PAR_EVEN   3'b011
`define PAR_ONE    3'b101
`define PAR_ZERO   3'b111
// Modem register bits
`define MDM_CHECK  0
`define MDM_DTR    1
`define MDM_RST    8'h02
// ----------------------------------------
// Flow characters
// ----------------------------------------
`define CH_ENQ     8'h05
`define CH_ACK     8'h06
`define CH_XON     8'h11
`define CH_XOFF    8'h13
// ----------------------------------------
// Timing: oversampling and baud x10 table
// ----------------------------------------
`define CLK_HZ     10000000
`define OVS        16
`define BAUD_X10_0 500
`define BAUD_X10_1 750
`define BAUD_X10_2 1100
`define BAUD_X10_3 1345
`define BAUD_X10_4 1500
`define BAUD_X10_5 2000
`define BAUD_X10_6 3000
`define BAUD_X10_7 6000
`define BAUD_X10_8 12000
`define BAUD_X10_9 18000
`define BAUD_X10_A 24000
`define BAUD_X10_B 36000
`define BAUD_X10_C 48000
`define BAUD_X10_D 72000
`define BAUD_X10_E 96000
`define BAUD_X10_F 192000
// Rounded clocks per 1/16 bit
`define DIV16(hz, b) (((hz) * 10 + ((b) * `OVS) / 2) / ((b) * `OVS))
`endif
